// ---- bench/cacc_asserts.sv ----
// Checker: port-level properties of the counter array
`timescale 1ns/1ns
`default_nettype none
module cacc_checker (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [11:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic i_WR,
  input wire logic [4:0] o_MOD_PIN_OE_N,
  input wire logic [4:0] o_MOD_IRQ,
  input wire logic o_WRAP_IRQ,
  input wire logic o_IRQ,
  input wire logic o_WDT_RESET
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_mm0_off;
    i_WR && i_ADDR == cacc_pkg::ADR_MMODE_BASE && !i_WDATA[0];
  endsequence
  sequence s_mm0_quiet;
    i_WR && i_ADDR == cacc_pkg::ADR_MMODE_BASE && i_WDATA[2:1] == 2'h0;
  endsequence
  sequence s_am_wr;
    i_WR && i_ADDR == cacc_pkg::ADR_ARRAY_MODE;
  endsequence
  a_irq_or: assert property (o_IRQ == (|o_MOD_IRQ || o_WRAP_IRQ))
    else $error("combined request mismatch");
  a_wrap_sw: assert property ($fell(o_WRAP_IRQ) |-> $past(i_WR))
    else $error("wrap request dropped without a write");
  a_flag_sw: assert property (
    |($past(o_MOD_IRQ) & ~o_MOD_IRQ) |-> $past(i_WR))
    else $error("module request dropped without a write");
  a_ie_off: assert property (s_mm0_off |=> !o_MOD_IRQ[0])
    else $error("module request not gated by its enable");
  a_pin_rel: assert property (s_mm0_quiet |=> o_MOD_PIN_OE_N[0])
    else $error("pin still driven with output modes off");
  a_wrap_ie: assert property (
    s_am_wr ##0 !i_WDATA[0] |=> !o_WRAP_IRQ)
    else $error("wrap request not gated by its enable");
  a_wdt_one: assert property (o_WDT_RESET |=> !o_WDT_RESET)
    else $error("watchdog pulse longer than one cycle");
  a_wdt_off: assert property (
    s_am_wr ##0 !i_WDATA[6] |=> ##1 !o_WDT_RESET)
    else $error("watchdog pulse while disabled");
endmodule
bind cacc_top cacc_checker u_chk (.*);
`default_nettype wire

// ---- bench/cacc_far.sv ----
// Far-side model: module pins, external count input, timer-0 overflow
`timescale 1ns/1ns
`default_nettype none
module cacc_far (
  input wire logic I_CLK,
  output logic [4:0] o_pin,
  output logic o_ext,
  output logic o_t0
);
  initial begin
    o_pin = 5'h00;
    o_ext = 1'b1;
    o_t0 = 1'b0;
  end
  // Period of 9 clocks keeps well under the quarter-rate ceiling
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge I_CLK) o_ext <= 1'b0;
      repeat (4) @(posedge I_CLK);
      o_ext <= 1'b1;
      repeat (4) @(posedge I_CLK);
    end
  endtask
  task automatic t0_pulses(input int n);
    repeat (n) begin
      @(posedge I_CLK) o_t0 <= 1'b1;
      @(posedge I_CLK) o_t0 <= 1'b0;
    end
  endtask
  task automatic t0_set(input logic b);
    @(posedge I_CLK) o_t0 <= b;
  endtask
  task automatic set_pin(input logic [4:0] v);
    @(posedge I_CLK) o_pin <= v;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the counter array
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [11:0] AM = cacc_pkg::ADR_ARRAY_MODE;
  localparam logic [11:0] AC = cacc_pkg::ADR_ARRAY_CTRL;
  localparam logic [11:0] MM = cacc_pkg::ADR_MMODE_BASE;
  localparam logic [11:0] VL = cacc_pkg::ADR_VAL_LO_BASE;
  logic clk, rst, wr, rd, idle, wdt_seen, ext, t0, wirq, irq, wdt;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, d, v;
  logic [4:0] pin_in, pin_out, oe_n, mirq;
  logic [15:0] cnt;
  int num_errors, cmp_count, cyc, seed;
  cacc_top u_dut (.I_CLK(clk), .I_RST(rst), .i_ADDR(addr), .i_WDATA(wdata),
    .i_WR(wr), .i_RD(rd), .o_RDATA(rdata), .i_EXT_COUNT(ext), .i_T0_OVF(t0),
    .i_IDLE(idle), .i_MOD_PIN(pin_in), .o_MOD_PIN(pin_out),
    .o_MOD_PIN_OE_N(oe_n), .o_MOD_IRQ(mirq), .o_WRAP_IRQ(wirq),
    .o_IRQ(irq), .o_WDT_RESET(wdt));
  cacc_far u_far (.I_CLK(clk), .o_pin(pin_in), .o_ext(ext), .o_t0(t0));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog pulse lasts one cycle, so it is latched here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt === 1'b1) wdt_seen <= 1'b1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_cnt(input logic [15:0] c);
    wr_reg(cacc_pkg::ADR_COUNT_LO, c[7:0]);
    wr_reg(cacc_pkg::ADR_COUNT_HI, c[15:8]);
  endtask
  task automatic rd_cnt();
    rd_reg(cacc_pkg::ADR_COUNT_LO);
    cnt[7:0] = d;
    rd_reg(cacc_pkg::ADR_COUNT_HI);
    cnt[15:8] = d;
  endtask
  function automatic logic [7:0] src_mode(input logic [1:0] s);
    return {5'h00, s, 1'b0};
  endfunction
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst, wr, rd, idle, wdt_seen, addr, wdata} = {1'b1, 24'h0};
    {num_errors, cmp_count, cyc, seed} = {96'h0, 32'hf77a};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(AM);
    chk("mode_rst", d, 0);
    v = 8'($random(seed));
    wr_reg(AM, v);
    rd_reg(AM);
    chk("mode_rw", d, v & cacc_pkg::AM_MASK);
    // Upper half of the address space holds no register
    rd_reg({1'b1, 11'($random(seed))});
    chk("unmapped", d, 0);
    for (int s = 2; s < 4; s++) begin
      set_cnt(0);
      wr_reg(AM, src_mode(2'(s)));
      wr_reg(AC, 8'h40);
      // Halt bit is off here, so idle must not matter
      idle <= 1'($random(seed));
      if (s == 2) u_far.t0_pulses(5);
      else u_far.ext_pulses(5);
      repeat (6) @(posedge clk);
      wr_reg(AC, 0);
      u_far.t0_pulses(3);
      u_far.t0_set(1'($random(seed)));
      u_far.t0_set(1'b0);
      idle <= 1'b0;
      rd_cnt();
      chk("src_count", cnt, 5);
    end
    wr_reg(AM, 8'h84);
    idle <= 1'b1;
    wr_reg(AC, 8'h40);
    u_far.t0_pulses(4);
    wr_reg(AC, 0);
    idle <= 1'b0;
    rd_cnt();
    chk("idle_hold", cnt, 5);
    wr_reg(AM, src_mode(0));
    wr_reg(AC, 8'h40);
    repeat (40) @(posedge clk);
    wr_reg(AC, 0);
    rd_cnt();
    chk("tick", cnt > 13 && cnt < 18, 1);
    v = 8'(($random(seed) & 32'h1f) + 32'h1);
    set_cnt(0);
    wr_reg(AM, 8'h44);
    wr_reg(MM, 8'h4d);
    wr_reg(MM + 12'h4, 8'h40);
    for (int m = 0; m < 5; m += 4) begin
      wr_reg(VL + m[11:0], v);
      wr_reg(cacc_pkg::ADR_VAL_HI_BASE + m[11:0], 0);
    end
    wr_reg(AC, 8'h40);
    u_far.t0_pulses(40);
    repeat (4) @(posedge clk);
    chk("mod_irq", {irq, mirq}, 6'h21);
    chk("flip_pin", {oe_n[0], pin_out[0]}, 2'b01);
    chk("wdt", wdt_seen, 1);
    rd_reg(AC);
    chk("match_flag", d, 8'h41);
    wr_reg(AC, 0);
    wr_reg(MM, 8'h0d);
    set_cnt(0);
    wr_reg(AC, 8'h40);
    u_far.t0_pulses(40);
    rd_reg(AC);
    chk("no_cmp", d, 8'h40);
    wr_reg(AC, 0);
    set_cnt(16'hffff);
    wr_reg(AM, 8'h05);
    wr_reg(AC, 8'h40);
    u_far.t0_pulses(3);
    #1 chk("wrap", {wirq, irq}, 2'b11);
    u_far.t0_pulses(2);
    #1 chk("wrap_hold", {wirq, irq}, 2'b11);
    wr_reg(AC, 0);
    #1 chk("wrap_clr", {wirq, irq}, 2'b00);
    rd_cnt();
    wr_reg(MM + 12'h1, 8'h21);
    // Other pins have no capture enabled; only pin 1 must rise
    u_far.set_pin(5'($random(seed)) | 5'h02);
    repeat (6) @(posedge clk);
    rd_reg(VL + 12'h1);
    chk("cap_val", d, cnt[7:0]);
    chk("cap_irq", mirq, 5'h02);
    // Duty reference reloads once the low byte wraps to zero
    wr_reg(cacc_pkg::ADR_VAL_HI_BASE + 12'h2, v);
    wr_reg(MM + 12'h2, 8'h02);
    set_cnt(16'h00fe);
    wr_reg(AC, 8'h40);
    u_far.t0_pulses(2);
    repeat (2) @(posedge clk);
    #1 chk("pwm_low", {oe_n[2], pin_out[2]}, 2'b00);
    wr_reg(cacc_pkg::ADR_COUNT_LO, v);
    #1 chk("pwm_high", {oe_n[2], pin_out[2]}, 2'b01);
    wr_reg(AC, 8'h01);
    #1 chk("sw_flag", mirq, 5'h01);
    wr_reg(MM, 8'h00);
    #1 chk("ie_gate", {oe_n[0], mirq[0]}, 2'b10);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- rtl/cacc_pkg.sv ----
// Package: register map, field positions and shared types
package cacc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_MOD = 5;
  localparam logic [11:0] ADR_ARRAY_MODE = 12'h490;
  localparam logic [11:0] ADR_ARRAY_CTRL = 12'h491;
  localparam logic [11:0] ADR_TICK_DIV = 12'h492;
  localparam logic [11:0] ADR_COUNT_LO = 12'h494;
  localparam logic [11:0] ADR_COUNT_HI = 12'h495;
  localparam logic [11:0] ADR_MMODE_BASE = 12'h4a0;
  localparam logic [11:0] ADR_VAL_LO_BASE = 12'h4b0;
  localparam logic [11:0] ADR_VAL_HI_BASE = 12'h4c0;
  // Array mode register fields
  localparam int unsigned AM_HALT_IDLE = 7;
  localparam int unsigned AM_WDT_EN = 6;
  localparam int unsigned AM_SRC_HI = 2;
  localparam int unsigned AM_SRC_LO = 1;
  localparam int unsigned AM_WRAP_IE = 0;
  localparam logic [7:0] AM_MASK = 8'hc7;
  // Array control register fields
  localparam int unsigned AC_WRAP = 7;
  localparam int unsigned AC_RUN = 6;
  // Module mode register fields
  localparam int unsigned MM_IE = 0;
  localparam int unsigned MM_PWM = 1;
  localparam int unsigned MM_FLIP = 2;
  localparam int unsigned MM_EQ_FLAG = 3;
  localparam int unsigned MM_CAP_FALL = 4;
  localparam int unsigned MM_CAP_RISE = 5;
  localparam int unsigned MM_CMP_EN = 6;
  localparam logic [7:0] MM_MASK = 8'h7f;
  // Prescaler divisor codes and masks
  localparam logic [1:0] DIV4 = 2'h0;
  localparam logic [1:0] DIV16 = 2'h1;
  localparam logic [5:0] MSK4 = 6'h03;
  localparam logic [5:0] MSK16 = 6'h0f;
  localparam logic [5:0] MSK64 = 6'h3f;
  localparam int unsigned WDT_MOD = 4;
  localparam logic [7:0] BYTE_ALL = 8'hff;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cacc_req_type;

  typedef struct packed {
    logic [15:0] count;
    logic [5:0] presc;
    logic [2:0] ext_sync;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_d;
    logic [7:0] amode;
    logic run;
    logic wrap;
    logic [4:0] ev;
    logic [1:0] tick_div;
    logic [4:0][6:0] mmode;
    logic [4:0][15:0] val;
    logic [4:0][7:0] pwm_ref;
    logic [4:0] flip;
    logic inc;
    logic wdt;
    logic [7:0] rdata;
  } cacc_state_type;
endpackage

// ---- rtl/cacc_top.sv ----
// Counter array: shared time base with five capture/compare modules
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module cacc_top #(
  parameter int unsigned NUM_MOD = cacc_pkg::NUM_MOD
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [11:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic i_WR,
  input wire logic i_RD,
  output logic [7:0] o_RDATA,
  input wire logic i_EXT_COUNT,
  input wire logic i_T0_OVF,
  input wire logic i_IDLE,
  input wire logic [4:0] i_MOD_PIN,
  output logic [4:0] o_MOD_PIN,
  output logic [4:0] o_MOD_PIN_OE_N,
  output logic [4:0] o_MOD_IRQ,
  output logic o_WRAP_IRQ,
  output logic o_IRQ,
  output logic o_WDT_RESET
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] base);
    in_bank = (a >= base) && (a < base + 12'(NUM_MOD));
  endfunction

  function automatic logic [2:0] idx(input logic [11:0] a,
                                     input logic [11:0] base);
    idx = 3'(a - base);
  endfunction

  cacc_pkg::cacc_state_type s_q, s_d;
  cacc_pkg::cacc_req_type req;
  logic [5:0] pmask;
  logic tick, step, ext_fall;
  logic [15:0] cnt_nx;
  logic [4:0] match, cap, pwm_lvl;

  assign req = '{addr: i_ADDR, wdata: i_WDATA, wr: i_WR, rd: i_RD};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Pins pass two flops; the edge stage compares the second with a third, delayed copy
    s_d.ext_sync = {s_q.ext_sync[1:0], i_EXT_COUNT};
    s_d.pin_s1 = i_MOD_PIN;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_d = s_q.pin_s2;
    s_d.presc = s_q.presc + 6'h01;
    case (s_q.tick_div)
      cacc_pkg::DIV4: pmask = cacc_pkg::MSK4;
      cacc_pkg::DIV16: pmask = cacc_pkg::MSK16;
      default: pmask = cacc_pkg::MSK64;
    endcase
    tick = (s_q.presc & pmask) == pmask;
    // Sampling at osc rate limits the external source to osc/4
    ext_fall = s_q.ext_sync[2] & ~s_q.ext_sync[1];
    if (!s_q.amode[cacc_pkg::AM_SRC_HI]) begin
      step = tick;
    end else if (!s_q.amode[cacc_pkg::AM_SRC_LO]) begin
      step = i_T0_OVF;
    end else begin
      step = ext_fall;
    end
    step = step & s_q.run
      & ~(i_IDLE & s_q.amode[cacc_pkg::AM_HALT_IDLE]);
    cnt_nx = s_q.count + 16'h0001;
    s_d.inc = step;
    s_d.wdt = 1'b0;
    if (step) begin
      s_d.count = cnt_nx;
    end
    if (step && s_q.count == 16'hffff) begin
      s_d.wrap = 1'b1;
    end
    for (int n = 0; n < NUM_MOD; n++) begin
      // Checked one cycle after each increment: once per count
      match[n] = s_q.inc && s_q.mmode[n][cacc_pkg::MM_CMP_EN]
        && s_q.count == s_q.val[n];
      cap[n] = (s_q.mmode[n][cacc_pkg::MM_CAP_RISE]
                & s_q.pin_s2[n] & ~s_q.pin_d[n])
             | (s_q.mmode[n][cacc_pkg::MM_CAP_FALL]
                & ~s_q.pin_s2[n] & s_q.pin_d[n]);
      pwm_lvl[n] = s_q.count[7:0] >= s_q.pwm_ref[n];
      if (s_q.inc && s_q.count[7:0] == 8'h00) begin
        s_d.pwm_ref[n] = s_q.val[n][15:8];
      end
      if (match[n] && s_q.mmode[n][cacc_pkg::MM_FLIP]) begin
        s_d.flip[n] = ~s_q.flip[n];
      end
    end
    // Register writes; hardware events below override them
    if (req.wr) begin
      if (req.addr == cacc_pkg::ADR_ARRAY_MODE) begin
        s_d.amode = req.wdata & cacc_pkg::AM_MASK;
      end
      if (req.addr == cacc_pkg::ADR_ARRAY_CTRL) begin
        s_d.wrap = req.wdata[cacc_pkg::AC_WRAP];
        s_d.run = req.wdata[cacc_pkg::AC_RUN];
        s_d.ev = req.wdata[4:0];
      end
      if (req.addr == cacc_pkg::ADR_TICK_DIV) begin
        s_d.tick_div = req.wdata[1:0];
      end
      if (req.addr == cacc_pkg::ADR_COUNT_LO) begin
        s_d.count[7:0] = req.wdata;
      end
      if (req.addr == cacc_pkg::ADR_COUNT_HI) begin
        s_d.count[15:8] = req.wdata;
      end
      if (in_bank(req.addr, cacc_pkg::ADR_MMODE_BASE)) begin
        s_d.mmode[idx(req.addr, cacc_pkg::ADR_MMODE_BASE)] =
          req.wdata[6:0];
      end
      if (in_bank(req.addr, cacc_pkg::ADR_VAL_LO_BASE)) begin
        s_d.val[idx(req.addr, cacc_pkg::ADR_VAL_LO_BASE)][7:0] =
          req.wdata;
      end
      if (in_bank(req.addr, cacc_pkg::ADR_VAL_HI_BASE)) begin
        s_d.val[idx(req.addr, cacc_pkg::ADR_VAL_HI_BASE)][15:8] =
          req.wdata;
      end
    end
    // Set beats a simultaneous software clear
    if (step && s_q.count == 16'hffff) begin
      s_d.wrap = 1'b1;
    end
    for (int n = 0; n < NUM_MOD; n++) begin
      if (cap[n]) begin
        s_d.val[n] = s_q.count;
        s_d.ev[n] = 1'b1;
      end
      if (match[n] && s_q.mmode[n][cacc_pkg::MM_EQ_FLAG]) begin
        s_d.ev[n] = 1'b1;
      end
    end
    if (match[cacc_pkg::WDT_MOD]
        && s_q.amode[cacc_pkg::AM_WDT_EN]) begin
      s_d.wdt = 1'b1;
    end
    // Read data stands for exactly the cycle after the strobe
    s_d.rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == cacc_pkg::ADR_ARRAY_MODE) begin
        s_d.rdata = s_q.amode;
      end
      if (req.addr == cacc_pkg::ADR_ARRAY_CTRL) begin
        s_d.rdata = {s_q.wrap, s_q.run, 1'b0, s_q.ev};
      end
      if (req.addr == cacc_pkg::ADR_TICK_DIV) begin
        s_d.rdata = {6'h00, s_q.tick_div};
      end
      if (req.addr == cacc_pkg::ADR_COUNT_LO) begin
        s_d.rdata = s_q.count[7:0];
      end
      if (req.addr == cacc_pkg::ADR_COUNT_HI) begin
        s_d.rdata = s_q.count[15:8];
      end
      if (in_bank(req.addr, cacc_pkg::ADR_MMODE_BASE)) begin
        s_d.rdata = {1'b0,
          s_q.mmode[idx(req.addr, cacc_pkg::ADR_MMODE_BASE)]};
      end
      if (in_bank(req.addr, cacc_pkg::ADR_VAL_LO_BASE)) begin
        s_d.rdata = s_q.val[idx(req.addr, cacc_pkg::ADR_VAL_LO_BASE)][7:0];
      end
      if (in_bank(req.addr, cacc_pkg::ADR_VAL_HI_BASE)) begin
        s_d.rdata =
          s_q.val[idx(req.addr, cacc_pkg::ADR_VAL_HI_BASE)][15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      o_MOD_PIN[n] = s_q.mmode[n][cacc_pkg::MM_PWM] ? pwm_lvl[n]
                   : s_q.flip[n];
      o_MOD_PIN_OE_N[n] = ~(s_q.mmode[n][cacc_pkg::MM_PWM]
                          | s_q.mmode[n][cacc_pkg::MM_FLIP]);
      o_MOD_IRQ[n] = s_q.ev[n] & s_q.mmode[n][cacc_pkg::MM_IE];
    end
  end
  assign o_WRAP_IRQ = s_q.wrap & s_q.amode[cacc_pkg::AM_WRAP_IE];
  assign o_IRQ = o_WRAP_IRQ | (|o_MOD_IRQ);
  assign o_RDATA = s_q.rdata;
  assign o_WDT_RESET = s_q.wdt;
endmodule
`default_nettype wire
